// *** rtl/cmc_defs.vh ***
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CMC_NCH          2
`define CMC_AW           8
`define CMC_DW           32
`define CMC_MEM_AW       3
`define CMC_MEM_DEPTH    8

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define CMC_A_GCTL       8'h00
`define CMC_A_GLOBAL_STATUS_REG       8'h04
`define CMC_A_GCFG       8'h08
`define CMC_A_GTST       8'h0c
`define CMC_A_CH_BASE    8'h20
`define CMC_A_CH_STRIDE  8'h20
`define CMC_O_CCTL       8'h00
`define CMC_O_CSTS       8'h04
`define CMC_O_CCFG       8'h08
`define CMC_O_CTST       8'h0c
`define CMC_O_CERR       8'h10

// ----------------------------------------------------------------
// mode codes, shared by control select and status fields
// ----------------------------------------------------------------
`define CMC_M_OPER       2'h0
`define CMC_M_RESET      2'h1
`define CMC_M_TEST       2'h2
`define CMC_M_STOP       2'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMC_F_SEL_LO     0
`define CMC_F_SLEEP      2
`define CMC_F_PEND       2
`define CMC_F_READY      3
`define CMC_F_CST_LO     4
`define CMC_F_LOCK       6
`define CMC_F_ELOCK      0

// ----------------------------------------------------------------
// communication states
// ----------------------------------------------------------------
`define CMC_C_IDLE       2'h0
`define CMC_C_RX         2'h1
`define CMC_C_TX         2'h2
`define CMC_C_BOFF       2'h3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define CMC_CTL_RST_SEL  2'h1
`define CMC_CTL_RST_SLP  1'b1
`define CMC_ZERO32       32'h0000_0000
`define CMC_SETTLE_LAST  3'h3
`define CMC_IDLE_BITS    4'hb
`define CMC_LOCK_BITS    6'h20
`define CMC_MEM_GCFG     3'h0
`define CMC_MEM_CH0      3'h1

`endif

// *** rtl/cmc_cfg_mem.v ***
`include "cmc_defs.vh"

// retained configuration store; read data come out of a register
module cmc_cfg_mem (
  input  wire                    mclk,
  input  wire                    reset,
  input  wire                    we,
  input  wire [`CMC_MEM_AW-1:0]  waddr,
  input  wire [`CMC_DW-1:0]      wdata,
  input  wire [`CMC_MEM_AW-1:0]  raddr,
  output reg  [`CMC_DW-1:0]      rdata
);

  reg [`CMC_DW-1:0] mem [0:`CMC_MEM_DEPTH-1];
  integer k;

  // ----------------------------------------------------------------
  // storage; mode entry never touches it, so settings survive
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (k = 0; k < `CMC_MEM_DEPTH; k = k + 1)
        mem[k] <= `CMC_ZERO32;
      rdata <= `CMC_ZERO32;
    end else begin
      if (we)
        mem[waddr] <= wdata;
      rdata <= mem[raddr];
    end
  end

endmodule // cmc_cfg_mem

// *** rtl/cmc_mode_ctrl.v ***
// Chosen here: the plain strobed port and the register addresses.
`include "cmc_defs.vh"

// Behaviour
// RULE1 - software waits for the global status to show a finished switch before rewriting the global mode field.
// RULE2 - software waits for the channel status to show a finished switch before rewriting the channel mode field.
// RULE3 - in communication mode a channel flags ready and goes active only after 11 recessive bits in a row.
// RULE4 - while the bus-lock flag is set a halt request is refused and software must ask for reset instead.
// RULE5 - global stop gates all clocks, keeps every value, allows reads and ignores writes; the code still takes writes to the global control word.
// RULE6 - entering global reset initialises the global test setting and serves for module configuration.
// RULE7 - global test mode stops all communication yet lets test settings be written.
// RULE8 - a channel communicates only while the module is in global operating mode.
// RULE9 - channel stop gates the channel clock, keeps its values, allows reads and ignores its writes; the code still takes channel control word writes.
// RULE10 - entering channel reset initialises the channel test setting and serves for channel configuration.
// RULE11 - channel halt stops communication and lets the channel test setting be written.
// RULE12 - in communication mode a channel is idle, receiving, transmitting or bus-off, exactly one of them.
// RULE13 - configuration words keep their value across global reset and channel reset entry.
// RULE14 - channel configuration words keep their value across channel halt entry.
// RULE15 - global mode changes force the channels into the matching mode.
// RULE16 - software finishes configuration before starting or restarting communication.
// RULE17 - status shows the active modes and changes only once a transition has completed.
module cmc_mode_ctrl (
  input  wire                    mclk,
  input  wire                    reset,
  input  wire [`CMC_AW-1:0]      addr,
  input  wire [`CMC_DW-1:0]      wdata,
  input  wire                    wr,
  input  wire                    rd,
  output wire [`CMC_DW-1:0]      rdata,
  input  wire [`CMC_NCH-1:0]     can_rx,
  input  wire [`CMC_NCH-1:0]     bit_tick,
  input  wire [`CMC_NCH-1:0]     rx_busy,
  input  wire [`CMC_NCH-1:0]     tx_busy,
  input  wire [`CMC_NCH-1:0]     bus_off,
  output wire                    glb_clk_en,
  output reg                     glb_cfg_init,
  output wire [`CMC_NCH-1:0]     ch_clk_en,
  output wire [`CMC_NCH-1:0]     ch_comm_en,
  output reg  [`CMC_NCH-1:0]     ch_cfg_init
);

  localparam [1:0] ST_OPER  = `CMC_M_OPER;
  localparam [1:0] ST_RESET = `CMC_M_RESET;
  localparam [1:0] ST_TEST  = `CMC_M_TEST;
  localparam [1:0] ST_STOP  = `CMC_M_STOP;
  localparam       NCH      = `CMC_NCH;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [1:0]          gctl_sel;
  reg                 gctl_sleep;
  reg  [1:0]          gact;
  reg  [2:0]          gcnt;
  reg  [`CMC_DW-1:0]  gtst;
  reg  [1:0]          cctl_sel   [0:NCH-1];
  reg                 cctl_sleep [0:NCH-1];
  reg  [1:0]          cact       [0:NCH-1];
  reg  [2:0]          ccnt       [0:NCH-1];
  reg  [`CMC_DW-1:0]  ctst       [0:NCH-1];
  reg  [3:0]          rcnt       [0:NCH-1];
  reg  [5:0]          dcnt       [0:NCH-1];
  reg  [NCH-1:0]      rdy;
  reg  [NCH-1:0]      lock;
  reg  [`CMC_DW-1:0]  rdata_q;
  reg                 rd_mem;
  reg  [1:0]          gtgt;
  reg  [1:0]          ctgt       [0:NCH-1];
  reg  [1:0]          cst        [0:NCH-1];
  reg                 g_ent_rst;
  reg  [NCH-1:0]      c_ent_rst;
  reg                 mem_we;
  reg  [`CMC_MEM_AW-1:0] mem_wa;
  reg  [`CMC_MEM_AW-1:0] mem_ra;
  reg  [`CMC_DW-1:0]  rd_val;
  reg                 rd_hit_mem;
  wire [`CMC_DW-1:0]  mem_q;
  integer             i;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // channel index of an address, or NCH when outside every window
  function integer ch_of;
    input [`CMC_AW-1:0] a;
    integer j;
    begin
      ch_of = NCH;
      for (j = 0; j < NCH; j = j + 1)
        if (a >= `CMC_A_CH_BASE + j * `CMC_A_CH_STRIDE &&
            a <  `CMC_A_CH_BASE + (j + 1) * `CMC_A_CH_STRIDE)
          ch_of = j;
    end
  endfunction

  // offset of an address inside its channel window
  function [`CMC_AW-1:0] ch_off;
    input [`CMC_AW-1:0] a;
    begin
      ch_off = (a - `CMC_A_CH_BASE) & (`CMC_A_CH_STRIDE - 8'h01);
    end
  endfunction

  // mode a channel heads for, given its request and the global mode
  function [1:0] ch_target;
    input [1:0] g;
    input       slp;
    input [1:0] sel;
    input [1:0] act;
    input       lk;
    reg   [1:0] t;
    begin
      t = slp ? ST_STOP : ((sel == ST_STOP) ? act : sel);
      if (act == ST_STOP && t != ST_STOP)
        t = ST_RESET;                            // stop only leaves via reset
      if (t == ST_STOP && act != ST_RESET && act != ST_STOP)
        t = ST_RESET;
      if (g == ST_RESET && t != ST_STOP)
        t = ST_RESET;                            // [RULE15]
      if (g == ST_TEST && t == ST_OPER)
        t = ST_TEST;                             // [RULE15] [RULE7]
      if (g == ST_STOP)
        t = ST_STOP;                             // [RULE15]
      if (t == ST_TEST && lk && act != ST_TEST)
        t = act;                                 // [RULE4]
      ch_target = t;
    end
  endfunction

  // ----------------------------------------------------------------
  // targets and entry events
  // ----------------------------------------------------------------
  // a settle counter separates request from completion, so status
  // never shows a mode that the logic has not reached yet
  always @* begin
    gtgt = gctl_sleep ? ST_STOP : ((gctl_sel == ST_STOP) ? gact : gctl_sel);
    if (gact == ST_STOP && gtgt != ST_STOP)
      gtgt = ST_RESET;
    if (gtgt == ST_STOP && gact != ST_RESET && gact != ST_STOP)
      gtgt = ST_RESET;
    g_ent_rst = (gtgt != gact) && (gcnt == `CMC_SETTLE_LAST) && (gtgt == ST_RESET);
    for (i = 0; i < NCH; i = i + 1) begin
      ctgt[i] = ch_target(gact, cctl_sleep[i], cctl_sel[i], cact[i], lock[i]);
      c_ent_rst[i] = (ctgt[i] != cact[i]) && (ccnt[i] == `CMC_SETTLE_LAST) &&
                     (ctgt[i] == ST_RESET);
      if (bus_off[i])
        cst[i] = `CMC_C_BOFF;                    // [RULE12]
      else if (tx_busy[i])
        cst[i] = `CMC_C_TX;
      else if (rx_busy[i])
        cst[i] = `CMC_C_RX;
      else
        cst[i] = `CMC_C_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // mode state machines
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      gact         <= ST_STOP;
      gcnt         <= 3'h0;
      glb_cfg_init <= 1'b0;
      ch_cfg_init  <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        cact[i] <= ST_STOP;
        ccnt[i] <= 3'h0;
      end
    end else begin
      glb_cfg_init <= g_ent_rst;                 // [RULE6]
      ch_cfg_init  <= c_ent_rst;                 // [RULE10]
      case (gtgt == gact)
        1'b1: gcnt <= 3'h0;
        1'b0: begin
          if (gcnt == `CMC_SETTLE_LAST) begin
            gact <= gtgt;                        // [RULE17]
            gcnt <= 3'h0;
          end else begin
            gcnt <= gcnt + 3'h1;
          end
        end
        default: gcnt <= 3'h0;
      endcase
      for (i = 0; i < NCH; i = i + 1) begin
        if (ctgt[i] == cact[i]) begin
          ccnt[i] <= 3'h0;
        end else if (ccnt[i] == `CMC_SETTLE_LAST) begin
          cact[i] <= ctgt[i];                    // [RULE17]
          ccnt[i] <= 3'h0;
        end else begin
          ccnt[i] <= ccnt[i] + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // bus integration and bus-lock watch
  // ----------------------------------------------------------------
  // counts run on the bit tick; a dominant bit restarts the idle
  // count, a recessive bit clears the lock
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdy  <= {NCH{1'b0}};
      lock <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        rcnt[i] <= 4'h0;
        dcnt[i] <= 6'h00;
      end
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (cact[i] != ST_OPER || bus_off[i]) begin
          rcnt[i] <= 4'h0;
          rdy[i]  <= 1'b0;
        end else if (bit_tick[i]) begin
          if (!can_rx[i])
            rcnt[i] <= 4'h0;
          else if (rcnt[i] != `CMC_IDLE_BITS)
            rcnt[i] <= rcnt[i] + 4'h1;
          if (can_rx[i] && rcnt[i] == `CMC_IDLE_BITS - 4'h1)
            rdy[i] <= 1'b1;                      // [RULE3]
        end
        if (bit_tick[i]) begin
          if (can_rx[i]) begin
            dcnt[i] <= 6'h00;
            lock[i] <= 1'b0;
          end else begin
            if (dcnt[i] != `CMC_LOCK_BITS)
              dcnt[i] <= dcnt[i] + 6'h01;
            if (dcnt[i] == `CMC_LOCK_BITS - 6'h01)
              lock[i] <= 1'b1;                   // [RULE4]
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // in global stop only the global control word takes writes, else
  // software could never wake the module again
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      gctl_sel   <= `CMC_CTL_RST_SEL;
      gctl_sleep <= `CMC_CTL_RST_SLP;
      gtst       <= `CMC_ZERO32;
      for (i = 0; i < NCH; i = i + 1) begin
        cctl_sel[i]   <= `CMC_CTL_RST_SEL;
        cctl_sleep[i] <= `CMC_CTL_RST_SLP;
        ctst[i]       <= `CMC_ZERO32;
      end
    end else begin
      if (wr && addr == `CMC_A_GCTL) begin
        gctl_sel   <= wdata[`CMC_F_SEL_LO +: 2];
        gctl_sleep <= wdata[`CMC_F_SLEEP];
      end
      if (wr && addr == `CMC_A_GTST && gact == ST_TEST)
        gtst <= wdata;                           // [RULE7]
      if (g_ent_rst)
        gtst <= `CMC_ZERO32;                     // [RULE6]
      for (i = 0; i < NCH; i = i + 1) begin
        if (wr && gact != ST_STOP && ch_of(addr) == i) begin  // [RULE5]
          if (ch_off(addr) == `CMC_O_CCTL) begin
            cctl_sel[i]   <= wdata[`CMC_F_SEL_LO +: 2];
            cctl_sleep[i] <= wdata[`CMC_F_SLEEP];
          end
          if (ch_off(addr) == `CMC_O_CTST && cact[i] == ST_TEST)
            ctst[i] <= wdata;                    // [RULE11] [RULE9]
        end
        if (g_ent_rst && cctl_sel[i] != ST_RESET)
          cctl_sel[i] <= ST_RESET;               // [RULE15]
        if (c_ent_rst[i])
          ctst[i] <= `CMC_ZERO32;                // [RULE10]
      end
    end
  end

  // configuration words go to the store, writable only in reset mode
  always @* begin
    mem_we = 1'b0;
    mem_wa = `CMC_MEM_GCFG;
    if (wr && addr == `CMC_A_GCFG && gact == ST_RESET) begin
      mem_we = 1'b1;                             // [RULE13]
    end
    for (i = 0; i < NCH; i = i + 1) begin
      if (wr && ch_of(addr) == i && ch_off(addr) == `CMC_O_CCFG &&
          cact[i] == ST_RESET && gact != ST_STOP) begin
        mem_we = 1'b1;                           // [RULE13] [RULE14] [RULE9]
        mem_wa = `CMC_MEM_CH0 + i[`CMC_MEM_AW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @* begin
    rd_val     = `CMC_ZERO32;
    rd_hit_mem = 1'b0;
    mem_ra     = `CMC_MEM_GCFG;
    case (addr)
      `CMC_A_GCTL: begin
        rd_val[`CMC_F_SEL_LO +: 2] = gctl_sel;
        rd_val[`CMC_F_SLEEP]       = gctl_sleep;
      end
      `CMC_A_GLOBAL_STATUS_REG: begin
        rd_val[`CMC_F_SEL_LO +: 2] = gact;        // [RULE17]
        rd_val[`CMC_F_PEND]        = (gtgt != gact);
      end
      `CMC_A_GCFG: rd_hit_mem = 1'b1;
      `CMC_A_GTST: rd_val = gtst;
      default: rd_val = `CMC_ZERO32;
    endcase
    for (i = 0; i < NCH; i = i + 1) begin
      if (ch_of(addr) == i) begin
        case (ch_off(addr))
          `CMC_O_CCTL: begin
            rd_val[`CMC_F_SEL_LO +: 2] = cctl_sel[i];
            rd_val[`CMC_F_SLEEP]       = cctl_sleep[i];
          end
          `CMC_O_CSTS: begin
            rd_val[`CMC_F_SEL_LO +: 2] = cact[i];     // [RULE17]
            rd_val[`CMC_F_PEND]        = (ctgt[i] != cact[i]);
            rd_val[`CMC_F_READY]       = rdy[i];      // [RULE3]
            rd_val[`CMC_F_CST_LO +: 2] = (cact[i] == ST_OPER) ? cst[i] : `CMC_C_IDLE;
            rd_val[`CMC_F_LOCK]        = lock[i];
          end
          `CMC_O_CCFG: begin
            rd_hit_mem = 1'b1;
            mem_ra     = `CMC_MEM_CH0 + i[`CMC_MEM_AW-1:0];
          end
          `CMC_O_CTST: rd_val = ctst[i];
          `CMC_O_CERR: rd_val[`CMC_F_ELOCK] = lock[i];  // [RULE4]
          default: rd_val = `CMC_ZERO32;
        endcase
      end
    end
  end

  // read data stand in the cycle after the strobe only; reads stay
  // legal in every mode, stop included
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_q <= `CMC_ZERO32;
      rd_mem  <= 1'b0;
    end else begin
      rd_mem  <= rd && rd_hit_mem;
      rdata_q <= (rd && !rd_hit_mem) ? rd_val : `CMC_ZERO32;  // [RULE5] [RULE9]
    end
  end

  assign rdata = rd_mem ? mem_q : rdata_q;

  // ----------------------------------------------------------------
  // configuration store
  // ----------------------------------------------------------------
  cmc_cfg_mem u_cfg (
    .mclk  (mclk),
    .reset (reset),
    .we    (mem_we),
    .waddr (mem_wa),
    .wdata (wdata),
    .raddr (mem_ra),
    .rdata (mem_q)
  );

  // ----------------------------------------------------------------
  // clock gates and communication enables
  // ----------------------------------------------------------------
  // active node only with the module operating, channel in
  // communication mode and bus integration done
  assign glb_clk_en = (gact != ST_STOP);         // [RULE5]
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      assign ch_clk_en[g]  = (cact[g] != ST_STOP) && glb_clk_en;  // [RULE9]
      assign ch_comm_en[g] = (gact == ST_OPER) && (cact[g] == ST_OPER) &&
                             rdy[g] && !bus_off[g];               // [RULE8] [RULE11] [RULE7]
    end
  endgenerate

endmodule // cmc_mode_ctrl

// *** tb/cmc_mode_sva.sv ***
`include "cmc_defs.vh"
// port watcher for the mode controller; channel 0 carries the bit-level checks
module cmc_mode_sva (
  input wire                mclk,
  input wire                reset,
  input wire [`CMC_AW-1:0]  addr,
  input wire [`CMC_DW-1:0]  wdata,
  input wire                wr,
  input wire                rd,
  input wire [`CMC_DW-1:0]  rdata,
  input wire [`CMC_NCH-1:0] can_rx,
  input wire [`CMC_NCH-1:0] bit_tick,
  input wire [`CMC_NCH-1:0] rx_busy,
  input wire [`CMC_NCH-1:0] tx_busy,
  input wire [`CMC_NCH-1:0] bus_off,
  input wire                glb_clk_en,
  input wire                glb_cfg_init,
  input wire [`CMC_NCH-1:0] ch_clk_en,
  input wire [`CMC_NCH-1:0] ch_comm_en,
  input wire [`CMC_NCH-1:0] ch_cfg_init
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] rec_cnt;
  // run of recessive bits seen on channel 0, saturating so it never wraps back below 11
  always @(posedge mclk or posedge reset) begin
    if (reset) rec_cnt <= 4'h0;
    else if (bit_tick[0]) rec_cnt <= !can_rx[0] ? 4'h0 : (rec_cnt == 4'hf ? rec_cnt : rec_cnt + 4'h1);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_rd_quiet; !$past(rd) |-> rdata == `CMC_ZERO32; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read cycle");
  property p_comm_clk; (ch_comm_en & ~ch_clk_en) == 2'h0; endproperty
  a_comm_clk: assert property (p_comm_clk) else $error("channel talks with clock gated");
  property p_glb_stop; !glb_clk_en |-> ch_clk_en == 2'h0 && ch_comm_en == 2'h0; endproperty
  a_glb_stop: assert property (p_glb_stop) else $error("channel live in global stop");
  property p_boff; (ch_comm_en & bus_off) == 2'h0; endproperty
  a_boff: assert property (p_boff) else $error("bus-off channel still active");
  property p_ready; $rose(ch_comm_en[0]) |-> rec_cnt >= 4'hb; endproperty
  a_ready: assert property (p_ready) else $error("active before 11 recessive bits");
  property p_ginit; glb_cfg_init |=> !glb_cfg_init; endproperty
  a_ginit: assert property (p_ginit) else $error("global init pulse too long");
  property p_ginit_quiet; glb_cfg_init |-> glb_clk_en && ch_comm_en == 2'h0; endproperty
  a_ginit_quiet: assert property (p_ginit_quiet) else $error("traffic during global reset");
  property p_cinit; ch_cfg_init[0] |-> !ch_comm_en[0] ##1 !ch_cfg_init[0]; endproperty
  a_cinit: assert property (p_cinit) else $error("bad channel init pulse");
  c_ready: cover property ($rose(ch_comm_en[0]));
  c_ginit: cover property (glb_cfg_init);
  c_cinit: cover property (ch_cfg_init[1]);
  c_stop: cover property ($fell(glb_clk_en));
endmodule // cmc_mode_sva

bind cmc_mode_ctrl cmc_mode_sva u_cmc_mode_sva (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .can_rx(can_rx), .bit_tick(bit_tick), .rx_busy(rx_busy),
  .tx_busy(tx_busy), .bus_off(bus_off), .glb_clk_en(glb_clk_en), .glb_cfg_init(glb_cfg_init),
  .ch_clk_en(ch_clk_en), .ch_comm_en(ch_comm_en), .ch_cfg_init(ch_cfg_init));

// *** tb/cmc_can_bus.sv ***
`include "cmc_defs.vh"
// far-side bus: one bit every 4 clocks, channels out of phase
module cmc_can_bus (
  input  wire                mclk,
  input  wire                reset,
  input  wire [`CMC_NCH-1:0] stuck_dom,
  input  wire [`CMC_NCH-1:0] st_rx,
  input  wire [`CMC_NCH-1:0] st_tx,
  input  wire [`CMC_NCH-1:0] st_boff,
  output reg  [`CMC_NCH-1:0] bit_tick,
  output wire [`CMC_NCH-1:0] can_rx,
  output wire [`CMC_NCH-1:0] rx_busy,
  output wire [`CMC_NCH-1:0] tx_busy,
  output wire [`CMC_NCH-1:0] bus_off
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] div;
  // bit timing
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      div      <= 2'h0;
      bit_tick <= 2'h0;
    end else begin
      div      <= div + 2'h1;
      bit_tick <= {div == 2'h1, div == 2'h3};
    end
  end
  // idle bus is recessive, a stuck node holds it dominant
  // between samples the level is inverted so an off-tick sample cannot pass
  assign can_rx  = ~stuck_dom ^ ~bit_tick;
  assign rx_busy = st_rx;
  assign tx_busy = st_tx;
  assign bus_off = st_boff;
endmodule // cmc_can_bus

// *** tb/can_fd_mode_state_control_tb.sv ***
`include "cmc_defs.vh"
module can_fd_mode_state_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, reset = 1, wr = 0, rd = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, d;
  logic [1:0]  stuck_dom = 0, st_rx = 0, st_tx = 0, st_boff = 0;
  wire  [31:0] rdata;
  wire  [1:0]  can_rx, bit_tick, rx_busy, tx_busy, bus_off, ch_clk_en, ch_comm_en, ch_cfg_init;
  wire         glb_clk_en, glb_cfg_init;
  int          num_errors = 0, num_checks = 0, n;
  // mode steps: control address, control value, expected active mode
  logic [15:0] rows [12] = '{16'h0011, 16'h0022, 16'h0011, 16'h2011, 16'h2053, 16'h2011,
                             16'h4011, 16'h0000, 16'h2000, 16'h4000, 16'h2022, 16'h2000};
  cmc_mode_ctrl u_cmc_mode_ctrl (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .can_rx(can_rx), .bit_tick(bit_tick), .rx_busy(rx_busy), .tx_busy(tx_busy),
    .bus_off(bus_off), .glb_clk_en(glb_clk_en), .glb_cfg_init(glb_cfg_init), .ch_clk_en(ch_clk_en),
    .ch_comm_en(ch_comm_en), .ch_cfg_init(ch_cfg_init));
  cmc_can_bus u_cmc_can_bus (.mclk(mclk), .reset(reset), .stuck_dom(stuck_dom), .st_rx(st_rx),
    .st_tx(st_tx), .st_boff(st_boff), .bit_tick(bit_tick), .can_rx(can_rx), .rx_busy(rx_busy),
    .tx_busy(tx_busy), .bus_off(bus_off));
  initial begin
    forever #2 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task rd_reg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // software side waits for pending to drop before any rewrite
  task wait_mode(input logic [7:0] a, input logic [1:0] m);
    repeat (2) @(posedge mclk);
    for (n = 0; n < 30; n++) begin
      rd_reg(a + 8'h04);
      if (d[2] === 1'b0) break;
    end
    chk(d[2:0], {1'b0, m});
  endtask
  task end_sim;
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a hang ends the run as a failure
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(8'h04); chk(d, 32'h3);
    rd_reg(8'h00); chk(d, 32'h5);
    chk({glb_clk_en, ch_clk_en}, 3'h0);
    for (int i = 0; i < 12; i++) begin
      wr_reg(rows[i][15:8], {28'h0, rows[i][7:4]});
      wait_mode(rows[i][15:8], rows[i][1:0]);
      if (i == 0) wr_reg(8'h08, 32'ha5);
      if (i == 1) begin
        wr_reg(8'h0c, 32'h77);
        rd_reg(8'h0c); chk(d, 32'h77);
        chk(ch_comm_en, 2'h0);
      end
      if (i == 2) begin
        rd_reg(8'h0c); chk(d, 32'h0);
      end
      if (i == 3) wr_reg(8'h28, 32'h3c);
      if (i == 4) begin
        chk(ch_clk_en[0], 1'b0);
        wr_reg(8'h28, 32'h0);
      end
      if (i == 10) begin
        wr_reg(8'h2c, 32'h5a);
        rd_reg(8'h2c); chk(d, 32'h5a);
        rd_reg(8'h28); chk(d, 32'h3c);
        chk(ch_comm_en[0], 1'b0);
      end
      if (i == 11) begin
        rd_reg(8'h24); chk(d[3], 1'b0);
      end
    end
    for (n = 0; n < 300 && ch_comm_en !== 2'h3; n++) @(posedge mclk);
    chk(ch_comm_en, 2'h3);
    rd_reg(8'h24); chk(d[3], 1'b1);
    // every communication state of channel 1, idle first
    for (int k = 0; k < 4; k++) begin
      st_rx   <= {k == 1, 1'b0};
      st_tx   <= {k == 2, 1'b0};
      st_boff <= {k == 3, 1'b0};
      rd_reg(8'h44); chk(d[5:4], k[1:0]);
    end
    chk(ch_comm_en[1], 1'b0);
    st_boff <= 2'h0;
    // stuck dominant bus on channel 0 blocks halt, reset still works
    stuck_dom <= 2'h1;
    repeat (180) @(posedge mclk);
    rd_reg(8'h30); chk(d[0], 1'b1);
    rd_reg(8'h24); chk(d[6], 1'b1);
    wr_reg(8'h20, 32'h2);
    repeat (10) @(posedge mclk);
    rd_reg(8'h24); chk(d[1:0], 2'h0);
    wr_reg(8'h20, 32'h1);
    wait_mode(8'h20, 2'h1);
    rd_reg(8'h2c); chk(d, 32'h0);
    rd_reg(8'h28); chk(d, 32'h3c);
    stuck_dom <= 2'h0;
    wr_reg(8'h00, 32'h1);
    wait_mode(8'h00, 2'h1);
    wait_mode(8'h40, 2'h1);
    rd_reg(8'h08); chk(d, 32'ha5);
    wr_reg(8'h00, 32'h5);
    wait_mode(8'h00, 2'h3);
    chk({glb_clk_en, ch_clk_en}, 3'h0);
    wr_reg(8'h08, 32'h0);
    rd_reg(8'h08); chk(d, 32'ha5);
    rd_reg(8'h1c); chk(d, 32'h0);
    // a reset in mid-run clears the retained store and parks the module in stop
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd_reg(8'h08); chk(d, 32'h0);
    rd_reg(8'h04); chk(d, 32'h3);
    rd_reg(8'h00); chk(d, 32'h5);
    end_sim();
  end
endmodule // can_fd_mode_state_control_tb
